// >>> logic/speaker_amp_power_control.sv
// speaker amplifier and audio path power control registers behind apb
// assumes pclk at 100 MHz, presetn asynchronous active low, 32-bit apb master
//
// Operation
// [R1] gain code 0 is -22 dB, 1 is +20 dB, minus 3 dB per step, 15 is -22 dB
// [R2] bits 6 and 5 select standby, precharge, active; both set is forbidden
// [R3] bit 4 low selects low power, high selects high power
// [R4] amplifier control at index 11h, bit 7 unused, resets to zero
// [R5] firmware powers headset path with ordered writes and 500 ms and 1 ms waits
// [R6] firmware powers headset path off with ordered writes and 1 ms wait
// [R7] firmware starts serial audio by pulsing resets under mask, waits 5 ms
// [R8] firmware turns converters off before stopping serial audio stream
// [R9] firmware precharges amplifier inputs before turning amplifier on
// [R10] firmware sets minimum gain before switching amplifier off
// [R11] fastcharge bit then power bit; charging runs while both set
// [R12] clearing a power bit unpowers the block until new full sequence
// [R13] all precharge bits may be set together
// [R14] codec reset index 10h: bit 2 mask, bit 1 filter reset, bit 0 codec reset
// [R15] precharge index 0Ch: bit 0 master power, bit 1 master precharge
// [R16] byte-wide registers readable and writable, unused bits read zero
`timescale 1ns/10ps
module speaker_amp_power_control
	import spk_amp_pkg::*;
#(
	parameter int GAIN_W = 4
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// amplifier controls
	output amp_ctrl_t spk_amp_ctrl,
	output amp_mode_t spk_amp_mode,
	output logic signed [7:0] spk_amp_gain_db,
	// codec reset controls
	output logic codec_reset_mask,
	output logic filter_reset_n,
	output logic codec_reset_n,
	// precharge and master power
	output logic [7:0] precharge_ctrl,
	output logic master_power_on,
	output logic master_precharge,
	output logic master_fastcharging
);
	if (GAIN_W != 4) begin : gain_width_check
		$error("gain field must be four bits");
	end

	// ****************************************************************
	// bus decode
	// ****************************************************************
	logic [7:0] amp_ctrl_q, amp_ctrl_d;
	logic [7:0] prech_q, prech_d;
	logic [2:0] rst_q, rst_d;
	logic [1:0] lost_q, lost_d;
	logic [7:0] status_rd;
	wire logic access = psel && penable;
	wire logic word_ok = (paddr[1:0] == 2'b00);
	wire logic [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
	wire logic hit_amp = word_ok && (idx == (ADDR_W-2)'(IDX_AMP_CTRL));
	wire logic hit_prech = word_ok && (idx == (ADDR_W-2)'(IDX_PRECHARGE));
	wire logic hit_rst = word_ok && (idx == (ADDR_W-2)'(IDX_CODEC_RST));
	wire logic hit_stat = word_ok && (idx == (ADDR_W-2)'(IDX_AMP_STATUS));
	wire logic mapped = hit_amp || hit_prech || hit_rst || hit_stat;
	wire logic wr = access && pwrite;
	wire logic [7:0] wbyte = pwdata[7:0];

	assign pready = 1'b1;
	assign pslverr = access && (!mapped || (pwrite && hit_stat));

	// ****************************************************************
	// gain decode
	// ****************************************************************
	function automatic logic signed [7:0] gain_db(input logic [3:0] code);
		logic signed [7:0] step;
		step = 8'(signed'({4'h0, code}));
		if (code == GAIN_MUTE_CODE || code == GAIN_ALT_MUTE_CODE)
			gain_db = GAIN_MIN_DB; // [R1]
		else
			gain_db = 8'(GAIN_MAX_DB - GAIN_STEP_DB * (step - 8'sd1)); // [R1]
	endfunction : gain_db

	// ****************************************************************
	// registers
	// ****************************************************************
	// bit 7 is unused and always stored as zero
	assign amp_ctrl_d = (wr && hit_amp) ? {1'b0, wbyte[6:0]} : amp_ctrl_q; // [R4] [R16]
	// any combination of precharge bits is accepted together
	assign prech_d = (wr && hit_prech) ? wbyte : prech_q; // [R13] [R15]
	assign rst_d = (wr && hit_rst) ? wbyte[2:0] : rst_q; // [R14]
	// sticky record that master power or amplifier power was dropped; cleared by writing one, set wins
	wire logic master_drop = prech_q[MASTER_ON_BIT] && !prech_d[MASTER_ON_BIT];
	wire logic amp_drop = amp_ctrl_q[AMP_ON_BIT] && !amp_ctrl_d[AMP_ON_BIT];
	wire logic [1:0] lost_clr = (wr && hit_stat) ? wbyte[1:0] : 2'b00;
	assign lost_d = (lost_q & ~lost_clr) | {amp_drop, master_drop}; // [R12]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amp_ctrl_q <= AMP_CTRL_RST; // [R4]
			prech_q <= PRECHARGE_RST;
			rst_q <= CODEC_RST_RST[2:0];
			lost_q <= 2'b00;
		end else begin
			amp_ctrl_q <= amp_ctrl_d;
			prech_q <= prech_d;
			rst_q <= rst_d;
			lost_q <= lost_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign spk_amp_ctrl.on = amp_ctrl_q[AMP_ON_BIT];
	assign spk_amp_ctrl.precharge = amp_ctrl_q[AMP_PRECH_BIT];
	assign spk_amp_ctrl.high_power = amp_ctrl_q[AMP_LP_BIT]; // [R3]
	assign spk_amp_ctrl.gain = amp_ctrl_q[3:0];
	always_comb begin
		unique case ({amp_ctrl_q[AMP_ON_BIT], amp_ctrl_q[AMP_PRECH_BIT]}) // [R2]
			2'b00: spk_amp_mode = AMP_STANDBY;
			2'b01: spk_amp_mode = AMP_PRECHARGE;
			2'b10: spk_amp_mode = AMP_ACTIVE;
			2'b11: spk_amp_mode = AMP_FORBIDDEN;
		endcase
	end
	assign spk_amp_gain_db = gain_db(amp_ctrl_q[3:0]); // [R1]
	assign codec_reset_mask = rst_q[RST_MASK_BIT]; // [R14]
	assign filter_reset_n = rst_q[FILT_RST_BIT];
	assign codec_reset_n = rst_q[CODEC_RST_BIT];
	assign precharge_ctrl = prech_q;
	assign master_power_on = prech_q[MASTER_ON_BIT]; // [R15]
	assign master_precharge = prech_q[MASTER_PRECH_BIT];
	// fast charge runs only once power is up with precharge still set
	assign master_fastcharging = master_power_on && master_precharge; // [R11]

	// status: bit 0 master power lost, bit 1 amplifier switched off, bits 3:2 mode
	assign status_rd = {4'h0, spk_amp_mode, lost_q};
	always_comb begin
		prdata = 32'h0000_0000;
		if (access && !pwrite) begin
			if (hit_amp) prdata = {24'h00_0000, amp_ctrl_q}; // [R16]
			else if (hit_prech) prdata = {24'h00_0000, prech_q};
			else if (hit_rst) prdata = {29'h0000_0000, rst_q};
			else if (hit_stat) prdata = {24'h00_0000, status_rd};
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_gain_map;
		@(posedge pclk) disable iff (!presetn)
		(spk_amp_ctrl.gain == 4'h1) |-> (spk_amp_gain_db == 8'sd20);
	endproperty
	a_gain_map: assert property (p_gain_map) else $error("gain code 1 not +20 dB"); // [R1]

	property p_gain_mute;
		@(posedge pclk) disable iff (!presetn)
		(spk_amp_ctrl.gain == 4'hF || spk_amp_ctrl.gain == 4'h0 || spk_amp_ctrl.gain == 4'hE)
			|-> (spk_amp_gain_db == ((spk_amp_ctrl.gain == 4'hE) ? -8'sd19 : -8'sd22));
	endproperty
	a_gain_mute: assert property (p_gain_mute) else $error("gain end codes wrong"); // [R1]

	property p_mode;
		@(posedge pclk) disable iff (!presetn)
		(spk_amp_ctrl.on && !spk_amp_ctrl.precharge) |-> (spk_amp_mode == AMP_ACTIVE);
	endproperty
	a_mode: assert property (p_mode) else $error("active mode not decoded"); // [R2]

	property p_prech_mode;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_amp && wbyte[6:5] == 2'b01) |=> (spk_amp_mode == AMP_PRECHARGE);
	endproperty
	a_prech_mode: assert property (p_prech_mode) else $error("precharge not entered"); // [R2]

	property p_power_level;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_amp) |=> (spk_amp_ctrl.high_power == $past(pwdata[4]));
	endproperty
	a_power_level: assert property (p_power_level) else $error("power level not stored"); // [R3]

	property p_bit7_zero;
		@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && hit_amp) |-> (prdata[31:7] == 25'h0);
	endproperty
	a_bit7_zero: assert property (p_bit7_zero) else $error("unused bits read nonzero"); // [R4]

	property p_all_prech;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_prech && wbyte == 8'hFF) |=> (precharge_ctrl == 8'hFF) && master_fastcharging;
	endproperty
	a_all_prech: assert property (p_all_prech) else $error("all precharge refused"); // [R13]

	property p_drop_sticky;
		@(posedge pclk) disable iff (!presetn)
		$fell(master_power_on) |-> (lost_q[0] == 1'b1);
	endproperty
	a_drop_sticky: assert property (p_drop_sticky) else $error("power loss not recorded"); // [R12]

	property p_lost_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_stat && wbyte[0] && !master_drop) |=> !lost_q[0];
	endproperty
	a_lost_clear: assert property (p_lost_clear) else $error("power loss flag not cleared"); // [R12]

	property p_codec_rst;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit_rst) |=> ({codec_reset_mask, filter_reset_n, codec_reset_n}
			== $past(pwdata[2:0]));
	endproperty
	a_codec_rst: assert property (p_codec_rst) else $error("codec reset bits wrong"); // [R14]

	c_active: cover property (@(posedge pclk) disable iff (!presetn)
		spk_amp_mode == AMP_PRECHARGE ##[1:100] spk_amp_mode == AMP_ACTIVE);
	c_fastcharge: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(master_fastcharging));
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
	c_status_clear: cover property (@(posedge pclk) disable iff (!presetn) $fell(lost_q[0]));
endmodule : speaker_amp_power_control

// >>> logic/spk_amp_pkg.sv
// package for the speaker amplifier power control block
// assumes a 32-bit apb bus; byte-wide registers in the low bits of each word
package spk_amp_pkg;
	// register indices (printed offsets are not all multiples of four)
	localparam logic [7:0] IDX_PRECHARGE = 8'h0C;
	localparam logic [7:0] IDX_CODEC_RST = 8'h10;
	localparam logic [7:0] IDX_AMP_CTRL = 8'h11;
	localparam logic [7:0] IDX_AMP_STATUS = 8'h12;
	localparam int ADDR_W = 12;
	// field positions of the amplifier control register
	localparam int AMP_ON_BIT = 6;
	localparam int AMP_PRECH_BIT = 5;
	localparam int AMP_LP_BIT = 4;
	// field positions of the codec reset register
	localparam int RST_MASK_BIT = 2;
	localparam int FILT_RST_BIT = 1;
	localparam int CODEC_RST_BIT = 0;
	// field positions of the precharge register
	localparam int MASTER_ON_BIT = 0;
	localparam int MASTER_PRECH_BIT = 1;
	// reset values and gain decode constants
	localparam logic [7:0] AMP_CTRL_RST = 8'h00;
	localparam logic [7:0] PRECHARGE_RST = 8'h00;
	localparam logic [7:0] CODEC_RST_RST = 8'h00;
	localparam logic [3:0] GAIN_MUTE_CODE = 4'h0;
	localparam logic [3:0] GAIN_ALT_MUTE_CODE = 4'hF;
	localparam logic signed [7:0] GAIN_MIN_DB = -8'sd22;
	localparam logic signed [7:0] GAIN_MAX_DB = 8'sd20;
	localparam logic signed [7:0] GAIN_STEP_DB = 8'sd3;

	typedef enum logic [1:0] {
		AMP_STANDBY,
		AMP_PRECHARGE,
		AMP_ACTIVE,
		AMP_FORBIDDEN
	} amp_mode_t;

	typedef struct packed {
		logic on;
		logic precharge;
		logic high_power;
		logic [3:0] gain;
	} amp_ctrl_t;
endpackage : spk_amp_pkg

// >>> verif/speaker_amp_power_control_tb.sv
// testbench for the speaker amplifier power control block
// assumes the design package is compiled first; apb master driven at rising edges
`timescale 1ns/10ps
module speaker_amp_power_control_tb;
	import spk_amp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	amp_ctrl_t spk_amp_ctrl;
	amp_mode_t spk_amp_mode;
	logic signed [7:0] spk_amp_gain_db;
	logic codec_reset_mask, filter_reset_n, codec_reset_n;
	logic [7:0] precharge_ctrl;
	logic master_power_on, master_precharge, master_fastcharging;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [31:0] rd;
	logic err;
	int g;
	speaker_amp_power_control speaker_amp_power_control_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .spk_amp_ctrl(spk_amp_ctrl),
		.spk_amp_mode(spk_amp_mode), .spk_amp_gain_db(spk_amp_gain_db),
		.codec_reset_mask(codec_reset_mask), .filter_reset_n(filter_reset_n),
		.codec_reset_n(codec_reset_n), .precharge_ctrl(precharge_ctrl),
		.master_power_on(master_power_on), .master_precharge(master_precharge),
		.master_fastcharging(master_fastcharging));
	// ****************
	// tasks
	// ****************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			n_mismatch++;
			wrap_up();
		end else begin
			@(negedge pclk);
		end
	endtask : apb
	function automatic logic [ADDR_W-1:0] adr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction : adr
	// ****************
	// stimulus
	// ****************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, adr(IDX_AMP_CTRL), 8'h00);
		chk(rd, 32'h0000_0000);
		chk(spk_amp_mode, AMP_STANDBY);
		chk(spk_amp_ctrl.high_power, 1'b0);
		chk({24'h00_0000, spk_amp_gain_db}, 32'h0000_00EA);
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, adr(IDX_AMP_CTRL), {4'h9, c[3:0]});
			apb(1'b0, adr(IDX_AMP_CTRL), 8'h00);
			chk({rd[31:1], err}, {24'h00_0000, 4'h1, c[3:0]} & 32'hFFFF_FFFE);
			chk(rd[7], 1'b0);
			chk(spk_amp_ctrl.high_power, 1'b1);
			g = (c == 0 || c == 15) ? -22 : 20 - 3 * (c - 1);
			chk({24'h00_0000, spk_amp_gain_db}, {24'h00_0000, g[7:0]});
		end
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, adr(IDX_AMP_CTRL), {1'b0, m[1:0], 5'h00});
			chk(spk_amp_mode, amp_mode_t'(m[1:0]));
			chk(spk_amp_ctrl.high_power, 1'b0);
		end
		apb(1'b1, adr(IDX_CODEC_RST), 8'hFF);
		apb(1'b0, adr(IDX_CODEC_RST), 8'h00);
		chk(rd, 32'h0000_0007);
		chk({codec_reset_mask, filter_reset_n, codec_reset_n}, 3'b111);
		apb(1'b1, adr(IDX_CODEC_RST), 8'h04);
		chk({codec_reset_mask, filter_reset_n, codec_reset_n}, 3'b100);
		apb(1'b1, adr(IDX_CODEC_RST), 8'h07);
		apb(1'b1, adr(IDX_CODEC_RST), 8'h03);
		chk({codec_reset_mask, filter_reset_n, codec_reset_n}, 3'b011);
		apb(1'b1, adr(IDX_PRECHARGE), 8'hFF);
		apb(1'b0, adr(IDX_PRECHARGE), 8'h00);
		chk(rd, 32'h0000_00FF);
		chk(precharge_ctrl, 8'hFF);
		chk({master_power_on, master_precharge, master_fastcharging}, 3'b111);
		apb(1'b1, adr(IDX_PRECHARGE), 8'h01);
		chk({master_power_on, master_precharge, master_fastcharging}, 3'b100);
		apb(1'b1, adr(IDX_PRECHARGE), 8'h00);
		chk({master_power_on, master_fastcharging}, 2'b00);
		// status: forbidden mode in bits 3:2, master power loss in bit 0
		apb(1'b0, adr(IDX_AMP_STATUS), 8'h00);
		chk(rd, 32'h0000_000D);
		apb(1'b1, adr(IDX_AMP_STATUS), 8'h01);
		chk(err, 1'b1);
		apb(1'b0, adr(IDX_AMP_STATUS), 8'h00);
		chk(rd, 32'h0000_000C);
		apb(1'b1, adr(8'h13), 8'h55);
		chk(err, 1'b1);
		apb(1'b0, adr(8'h13), 8'h00);
		chk(rd, 32'h0000_0000);
		chk(err, 1'b1);
		apb(1'b0, adr(IDX_AMP_CTRL) | 12'h001, 8'h00);
		chk(rd, 32'h0000_0000);
		chk(err, 1'b1);
		chk(spk_amp_mode, AMP_FORBIDDEN);
		// clean amplifier power-up and power-down
		apb(1'b1, adr(IDX_AMP_CTRL), 8'h20);
		chk(spk_amp_mode, AMP_PRECHARGE);
		apb(1'b1, adr(IDX_AMP_CTRL), 8'h40);
		chk(spk_amp_mode, AMP_ACTIVE);
		chk({24'h00_0000, spk_amp_gain_db}, 32'h0000_00EA);
		apb(1'b1, adr(IDX_AMP_CTRL), 8'h00);
		apb(1'b0, adr(IDX_AMP_STATUS), 8'h00);
		chk(rd, 32'h0000_0002);
		apb(1'b1, adr(IDX_CODEC_RST), 8'h00);
		chk({codec_reset_mask, filter_reset_n, codec_reset_n}, 3'b000);
		wrap_up();
	end
endmodule : speaker_amp_power_control_tb
